// ### pkg/power_sleep_pkg.sv
package power_sleep_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_DOMAINS = 6;
  localparam int NUM_MODULES = 12;
  localparam int NUM_CORES   = 3;
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int FIRST_CORE_MODULE = 3;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] PID_OFS      = 12'h000;
  localparam logic [11:0] TR_CMD_OFS   = 12'h120;
  localparam logic [11:0] TR_STAT_OFS  = 12'h128;
  localparam logic [11:0] PDSTAT_OFS   = 12'h200;
  localparam logic [11:0] DOM_CTL_BASE = 12'h300;
  localparam logic [11:0] MDSTAT_BASE  = 12'h800;
  localparam logic [11:0] MOD_CTL_BASE = 12'hA00;
  localparam int          REG_STRIDE   = 4;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int PD_NEXT_BIT = 0;
  localparam int MD_NEXT_LSB = 0;
  localparam int MD_NEXT_W   = 3;
  localparam int LRST_BIT    = 8;

  localparam logic [2:0]  MD_STATE_ENABLE   = 3'h3;
  localparam logic [2:0]  MD_STATE_DISABLED = 3'h0;
  localparam logic        PD_STATE_ON       = 1'h1;

  localparam logic [5:0]  PERM_DOMAINS      = 6'h01;
  localparam logic [11:0] PERM_MODULES      = 12'h838;
  localparam logic [11:0] DEDICATED_MODULES = 12'h7C0;

  // arbitrary identification value
  localparam logic [31:0] PID_VALUE = 32'h0001_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int MEM_WAKE_NS     = 100;
  localparam int MEM_WAKE_CYCLES =
    ((MEM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((MEM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CNT_W           = 8;
  localparam int MODULE_CLK_DIV  = 4;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAKE,
    SEQ_CLOCK,
    SEQ_RESET
  } seq_state_t;

endpackage

// ### rtl/tick_divider.sv
`timescale 1ns/10ps
`default_nettype none

module tick_divider #(
  parameter int DIV = 4
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // tick out
  output logic      tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  always_comb begin
    tick_next = (cnt_reg == LAST);
    cnt_next  = tick_next ? '0 : cnt_reg + W'(1);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

`default_nettype wire

// ### rtl/clock_gate_cell.sv
`timescale 1ns/10ps
`default_nettype none

module clock_gate_cell #(
  parameter logic RESET_ON = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic tick,
  input  wire logic want,
  // gated branch
  output logic      clk_en,
  output logic      running
);

  logic gate_reg;
  logic gate_next;
  logic en_reg;
  logic en_next;

  // ----------------------------------------
  // gate moves only on a tick, so no pulse is cut short
  // ----------------------------------------
  always_comb begin
    gate_next = tick ? want : gate_reg;
    en_next   = tick & want;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_reg <= RESET_ON;
      en_reg   <= 1'b0;
    end else begin
      gate_reg <= gate_next;
      en_reg   <= en_next;
    end
  end

  assign clk_en  = en_reg;
  assign running = gate_reg;

endmodule

`default_nettype wire

// ### rtl/power_sleep_controller.sv
`timescale 1ns/10ps
`default_nettype none

module power_sleep_controller #(
  parameter int MEM_WAKE_CYCLES = power_sleep_pkg::MEM_WAKE_CYCLES,
  parameter int CLK_DIV         = power_sleep_pkg::MODULE_CLK_DIV
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // domain memories
  output logic      [5:0]  mem_sleep,
  // managed modules
  output logic      [11:0] module_reset_n,
  output logic      [11:0] module_clk_en,
  // pll clock controller
  output logic      [11:0] pll_clk_req,
  input  wire logic [11:0] pll_clk_ack,
  // cores
  input  wire logic [2:0]  core_wdog_reset_n,
  output logic      [2:0]  core_local_reset_n
);

  localparam int ND = power_sleep_pkg::NUM_DOMAINS;
  localparam int NM = power_sleep_pkg::NUM_MODULES;
  localparam int NC = power_sleep_pkg::NUM_CORES;
  localparam int AW = power_sleep_pkg::ADDR_W;
  localparam int DW = power_sleep_pkg::DATA_W;
  localparam int CW = power_sleep_pkg::CNT_W;
  localparam int FC = power_sleep_pkg::FIRST_CORE_MODULE;
  localparam int NL = power_sleep_pkg::MD_NEXT_LSB;
  localparam int NW = power_sleep_pkg::MD_NEXT_W;
  localparam int LB = power_sleep_pkg::LRST_BIT;
  localparam int PB = power_sleep_pkg::PD_NEXT_BIT;
  localparam logic [NM-1:0] PERM_M = power_sleep_pkg::PERM_MODULES;
  localparam logic [ND-1:0] PERM_D = power_sleep_pkg::PERM_DOMAINS;
  localparam logic [NM-1:0] DED_M  = power_sleep_pkg::DEDICATED_MODULES;

  // ----------------------------------------
  // state
  // ----------------------------------------
  power_sleep_pkg::seq_state_t state_reg, state_next;
  logic [CW-1:0]   cnt_reg, cnt_next;
  logic [ND-1:0]   pd_next_reg, pd_next_next;
  logic [ND-1:0]   mem_sleep_reg, mem_sleep_next;
  logic [NW-1:0]   md_next_reg [NM];
  logic [NW-1:0]   md_next_next [NM];
  logic [NM-1:0]   md_en_reg, md_en_next;
  logic [NM-1:0]   clk_want_reg, clk_want_next;
  logic [NM-1:0]   pll_req_reg, pll_req_next;
  logic [NM-1:0]   rst_n_reg, rst_n_next;
  logic [NM-1:0]   tgt_reg, tgt_next;
  logic [ND-1:0]   go_pend_reg, go_pend_next;
  logic [ND-1:0]   busy_reg, busy_next;
  logic [ND-1:0]   active_reg, active_next;
  logic [NC-1:0]   lrst_field_reg, lrst_field_next;
  logic [NC-1:0]   core_rst_n_reg, core_rst_n_next;
  logic [DW-1:0]   rdata_reg, rdata_next;

  logic            tick;
  logic [NM-1:0]   gate_running;
  logic [NM-1:0]   gate_clk_en;
  logic [NM-1:0]   running;
  logic [ND-1:0]   go_wr;

  // ----------------------------------------
  // clock-safe gating of shared branches
  // ----------------------------------------
  tick_divider #(
    .DIV (CLK_DIV)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick)
  );

  // dedicated modules get want = 0 here; their clock comes from the pll
  for (genvar i = 0; i < NM; i++) begin : g_gate
    clock_gate_cell #(
      .RESET_ON (PERM_M[i] & ~DED_M[i])
    ) u_gate (
      .sys_clk (sys_clk),
      .rst     (rst),
      .tick    (tick),
      .want    (clk_want_reg[i] & ~DED_M[i]),
      .clk_en  (gate_clk_en[i]),
      .running (gate_running[i])
    );
  end

  assign running = (gate_running & ~DED_M) | (pll_clk_ack & DED_M);

  // ----------------------------------------
  // register writes and transition sequencer
  // ----------------------------------------
  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    pd_next_next    = pd_next_reg;
    mem_sleep_next  = mem_sleep_reg;
    md_next_next    = md_next_reg;
    md_en_next      = md_en_reg;
    clk_want_next   = clk_want_reg;
    pll_req_next    = pll_req_reg;
    rst_n_next      = rst_n_reg;
    tgt_next        = tgt_reg;
    go_pend_next    = go_pend_reg;
    busy_next       = busy_reg;
    active_next     = active_reg;
    lrst_field_next = lrst_field_reg;
    go_wr           = '0;

    if (reg_wr) begin
      if (reg_addr == power_sleep_pkg::TR_CMD_OFS) begin
        go_wr = reg_wdata[ND-1:0];
      end
      for (int i = 0; i < ND; i++) begin
        if (reg_addr == AW'(int'(power_sleep_pkg::DOM_CTL_BASE)
                            + power_sleep_pkg::REG_STRIDE * i)) begin
          pd_next_next[i] = reg_wdata[PB];
        end
      end
      for (int i = 0; i < NM; i++) begin
        if (reg_addr == AW'(int'(power_sleep_pkg::MOD_CTL_BASE)
                            + power_sleep_pkg::REG_STRIDE * i)) begin
          md_next_next[i] = reg_wdata[NL +: NW];
          if (i >= FC && i < FC + NC) begin
            lrst_field_next[i-FC] = reg_wdata[LB];
          end
        end
      end
    end

    unique case (state_reg)
      power_sleep_pkg::SEQ_IDLE: begin
        if (go_pend_reg != '0) begin
          active_next  = go_pend_reg;
          go_pend_next = '0;
          // only wakes: an ON to OFF request is ignored
          for (int i = 0; i < ND; i++) begin
            if (go_pend_reg[i] && pd_next_reg[i] == power_sleep_pkg::PD_STATE_ON) begin
              mem_sleep_next[i] = 1'b0;
            end
          end
          // only enables: leaving enabled is never done
          for (int i = 0; i < NM; i++) begin
            tgt_next[i] = (md_next_reg[i] == power_sleep_pkg::MD_STATE_ENABLE)
                          & ~md_en_reg[i];
          end
          cnt_next   = CW'(MEM_WAKE_CYCLES);
          state_next = power_sleep_pkg::SEQ_WAKE;
        end
      end
      power_sleep_pkg::SEQ_WAKE: begin
        if (cnt_reg > CW'(1)) begin
          cnt_next = cnt_reg - CW'(1);
        end else begin
          clk_want_next = clk_want_reg | tgt_reg;
          pll_req_next  = pll_req_reg | (tgt_reg & DED_M);
          state_next    = power_sleep_pkg::SEQ_CLOCK;
        end
      end
      power_sleep_pkg::SEQ_CLOCK: begin
        if ((running & tgt_reg) == tgt_reg) begin
          state_next = power_sleep_pkg::SEQ_RESET;
        end
      end
      power_sleep_pkg::SEQ_RESET: begin
        rst_n_next  = rst_n_reg | tgt_reg;
        md_en_next  = md_en_reg | tgt_reg;
        tgt_next    = '0;
        busy_next   = busy_reg & ~active_reg;
        active_next = '0;
        state_next  = power_sleep_pkg::SEQ_IDLE;
      end
    endcase

    // a new trigger in the clearing cycle still sets its bit
    go_pend_next = go_pend_next | go_wr;
    busy_next    = busy_next | go_wr;

    // permanent domain and modules cannot be switched off
    mem_sleep_next = mem_sleep_next & ~PERM_D;
    md_en_next     = md_en_next | PERM_M;
  end

  // ----------------------------------------
  // core local reset
  // ----------------------------------------
  // memories of the core are not touched; on release it runs from l2
  always_comb begin
    core_rst_n_next = lrst_field_reg & core_wdog_reset_n;
  end

  // ----------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      if (reg_addr == power_sleep_pkg::PID_OFS) begin
        rdata_next = power_sleep_pkg::PID_VALUE;
      end
      if (reg_addr == power_sleep_pkg::TR_STAT_OFS) begin
        rdata_next[ND-1:0] = busy_reg;
      end
      if (reg_addr == power_sleep_pkg::PDSTAT_OFS) begin
        rdata_next[ND-1:0] = ~mem_sleep_reg;
      end
      for (int i = 0; i < ND; i++) begin
        if (reg_addr == AW'(int'(power_sleep_pkg::DOM_CTL_BASE)
                            + power_sleep_pkg::REG_STRIDE * i)) begin
          rdata_next[PB] = pd_next_reg[i];
        end
      end
      for (int i = 0; i < NM; i++) begin
        if (reg_addr == AW'(int'(power_sleep_pkg::MDSTAT_BASE)
                            + power_sleep_pkg::REG_STRIDE * i)) begin
          rdata_next[NL +: NW] = md_en_reg[i] ? power_sleep_pkg::MD_STATE_ENABLE
                                              : power_sleep_pkg::MD_STATE_DISABLED;
          if (i >= FC && i < FC + NC) begin
            rdata_next[LB] = core_rst_n_reg[i-FC];
          end
        end
        if (reg_addr == AW'(int'(power_sleep_pkg::MOD_CTL_BASE)
                            + power_sleep_pkg::REG_STRIDE * i)) begin
          rdata_next[NL +: NW] = md_next_reg[i];
          if (i >= FC && i < FC + NC) begin
            rdata_next[LB] = lrst_field_reg[i-FC];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= power_sleep_pkg::SEQ_IDLE;
      cnt_reg        <= '0;
      pd_next_reg    <= PERM_D;
      mem_sleep_reg  <= ~PERM_D;
      md_en_reg      <= PERM_M;
      clk_want_reg   <= PERM_M;
      pll_req_reg    <= PERM_M & DED_M;
      rst_n_reg      <= PERM_M;
      tgt_reg        <= '0;
      go_pend_reg    <= '0;
      busy_reg       <= '0;
      active_reg     <= '0;
      lrst_field_reg <= '1;
      core_rst_n_reg <= '1;
      rdata_reg      <= '0;
      for (int i = 0; i < NM; i++) begin
        md_next_reg[i] <= PERM_M[i] ? power_sleep_pkg::MD_STATE_ENABLE
                                    : power_sleep_pkg::MD_STATE_DISABLED;
      end
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      pd_next_reg    <= pd_next_next;
      mem_sleep_reg  <= mem_sleep_next;
      md_en_reg      <= md_en_next;
      clk_want_reg   <= clk_want_next;
      pll_req_reg    <= pll_req_next;
      rst_n_reg      <= rst_n_next;
      tgt_reg        <= tgt_next;
      go_pend_reg    <= go_pend_next;
      busy_reg       <= busy_next;
      active_reg     <= active_next;
      lrst_field_reg <= lrst_field_next;
      core_rst_n_reg <= core_rst_n_next;
      rdata_reg      <= rdata_next;
      md_next_reg    <= md_next_next;
    end
  end

  assign reg_rdata          = rdata_reg;
  assign mem_sleep          = mem_sleep_reg;
  assign module_reset_n     = rst_n_reg;
  assign module_clk_en      = gate_clk_en;
  assign pll_clk_req        = pll_req_reg;
  assign core_local_reset_n = core_rst_n_reg;

endmodule

`default_nettype wire

// ### sim/power_sleep_checker.sv
`timescale 1ns/10ps
`default_nettype none

module power_sleep_checker #(
  parameter int MEM_WAKE_CYCLES = 2,
  parameter int CLK_DIV         = 4
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // domains and modules
  input  wire logic [5:0]  mem_sleep,
  input  wire logic [11:0] module_reset_n,
  input  wire logic [11:0] module_clk_en,
  input  wire logic [11:0] pll_clk_req,
  input  wire logic [11:0] pll_clk_ack,
  // cores
  input  wire logic [2:0]  core_wdog_reset_n,
  input  wire logic [2:0]  core_local_reset_n
);
  localparam int          EN_GAP = CLK_DIV + 1;
  localparam logic [11:0] DED    = power_sleep_pkg::DEDICATED_MODULES;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  perm_domain_a: assert property (mem_sleep[0] == 1'b0)
    else $error("permanent domain asleep");
  perm_modules_a: assert property ((module_reset_n & 12'h838) == 12'h838)
    else $error("permanent module in reset");
  dedicated_gate_a: assert property ((module_clk_en & DED) == 12'h000)
    else $error("dedicated clock gated locally");
  shared_req_a: assert property ((pll_clk_req & ~DED) == 12'h000)
    else $error("shared clock requested from pll");
  reset_hold_a: assert property ((~module_reset_n & $past(module_reset_n)) == 12'h000)
    else $error("module left enabled state");
  sleep_hold_a: assert property ((mem_sleep & ~$past(mem_sleep)) == 6'h00)
    else $error("domain went back to sleep");
  ded_order_a: assert property (((module_reset_n & ~$past(module_reset_n) & DED)
      & ~$past(pll_clk_req & pll_clk_ack)) == 12'h000)
    else $error("reset released before dedicated clock ran");
  ded_running_a: assert property (((module_reset_n & DED) & ~pll_clk_req) == 12'h000)
    else $error("enabled dedicated module without clock");
  wake_first_a: assert property ((|(~mem_sleep & $past(mem_sleep)))
      |-> ##1 $stable(module_reset_n) [*2])
    else $error("module reset released during memory wake");
  clk_pulse_a: assert property ((module_clk_en & $past(module_clk_en)) == 12'h000)
    else $error("clock enable longer than one cycle");
  wdog_reset_a: assert property ((core_local_reset_n & ~$past(core_wdog_reset_n)) == 3'h0)
    else $error("watchdog reset not passed to core");

  // only safe clock for a shared module: the enable pulses must keep coming
  for (genvar i = 0; i < 12; i++) begin : g_shared
    if (!DED[i]) begin : g_on
      // the release edge itself still sees reset, the divider starts one edge later
      shared_run_a: assert property ((!rst && module_reset_n[i]) |-> ##[0:EN_GAP] module_clk_en[i])
        else $error("enabled shared module without clock");
    end
  end
endmodule

bind power_sleep_controller power_sleep_checker #(
  .MEM_WAKE_CYCLES(MEM_WAKE_CYCLES),
  .CLK_DIV(CLK_DIV)
) u_checker (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_sleep(mem_sleep),
  .module_reset_n(module_reset_n), .module_clk_en(module_clk_en),
  .pll_clk_req(pll_clk_req), .pll_clk_ack(pll_clk_ack),
  .core_wdog_reset_n(core_wdog_reset_n), .core_local_reset_n(core_local_reset_n)
);

`default_nettype wire

// ### sim/pll_clock_model.sv
`timescale 1ns/10ps
`default_nettype none

module pll_clock_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // requests
  input  wire logic [11:0] pll_clk_req,
  input  wire logic        slow,
  // answers
  output logic      [11:0] pll_clk_ack
);
  logic [3:0] wait_reg;

  // slow mode makes the sequencer really wait on the ack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_reg    <= 4'h0;
      pll_clk_ack <= 12'h000;
    end else if ((pll_clk_req & ~pll_clk_ack) == 12'h000) begin
      wait_reg    <= 4'h0;
      pll_clk_ack <= pll_clk_req;
    end else if (wait_reg >= (slow ? 4'h7 : 4'h0)) begin
      wait_reg    <= 4'h0;
      pll_clk_ack <= pll_clk_req;
    end else begin
      wait_reg    <= wait_reg + 4'h1;
    end
  end
endmodule

`default_nettype wire

// ### sim/tb_power_sleep_controller.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((exp) !== (got)) begin n_fail++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end

module tb_power_sleep_controller;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk           = 1'b0;
  logic        rst               = 1'b1;
  logic [11:0] reg_addr          = 12'h000;
  logic [31:0] reg_wdata         = 32'h0000_0000;
  logic        reg_wr            = 1'b0;
  logic        reg_rd            = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0]  mem_sleep;
  logic [11:0] module_reset_n;
  logic [11:0] module_clk_en;
  logic [11:0] pll_clk_req;
  logic [11:0] pll_clk_ack;
  logic [2:0]  core_wdog_reset_n = 3'h7;
  logic [2:0]  core_local_reset_n;
  logic        slow              = 1'b0;
  logic [31:0] seed              = 32'h0001_249E;
  logic [31:0] rd_val;
  int          mods[5]           = '{0, 6, 7, 1, 8};
  int          check_count       = 0;
  int          n_fail            = 0;
  int          cycles            = 0;

  always #25 sys_clk = ~sys_clk;

  power_sleep_controller #(.MEM_WAKE_CYCLES(2), .CLK_DIV(4)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_sleep(mem_sleep),
    .module_reset_n(module_reset_n), .module_clk_en(module_clk_en),
    .pll_clk_req(pll_clk_req), .pll_clk_ack(pll_clk_ack),
    .core_wdog_reset_n(core_wdog_reset_n), .core_local_reset_n(core_local_reset_n)
  );

  pll_clock_model u_pll (
    .sys_clk(sys_clk), .rst(rst), .pll_clk_req(pll_clk_req), .slow(slow),
    .pll_clk_ack(pll_clk_ack)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] ofs(input logic [11:0] base, input int i);
    return base + 12'(4 * i);
  endfunction

  function automatic logic [31:0] pd_bit(input int d);
    return 32'h1 << d;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] addr, output logic [31:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    data = reg_rdata;
  endtask

  task automatic check_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("sleep_rst", 6'h3E, mem_sleep)
    `CHK("mreset_rst", power_sleep_pkg::PERM_MODULES, module_reset_n)
    `CHK("lreset_rst", 3'h7, core_local_reset_n)
    `CHK("req_rst", 12'h000, pll_clk_req)
    `CHK("clken_rst", 12'h000, module_clk_en)
    @(posedge sys_clk) rst <= 1'b0;
  endtask

  task automatic wait_idle(input int d);
    int n = 0;
    reg_read(power_sleep_pkg::TR_STAT_OFS, rd_val);
    while (rd_val[d] !== 1'b0 && n < 40) begin
      reg_read(power_sleep_pkg::TR_STAT_OFS, rd_val);
      n++;
    end
    `CHK("pending_clear", 1'b0, rd_val[d])
  endtask

  task automatic go(input int d, input int m);
    reg_write(ofs(power_sleep_pkg::DOM_CTL_BASE, d), 32'h1);
    reg_write(ofs(power_sleep_pkg::MOD_CTL_BASE, m), 32'h103);
    reg_write(power_sleep_pkg::TR_CMD_OFS, pd_bit(d));
    reg_read(power_sleep_pkg::TR_STAT_OFS, rd_val);
    `CHK("pending_set", pd_bit(d), rd_val)
    wait_idle(d);
    `CHK("mem_awake", 1'b0, mem_sleep[d])
    `CHK("mod_enabled", 1'b1, module_reset_n[m])
    reg_read(ofs(power_sleep_pkg::MDSTAT_BASE, m), rd_val);
    `CHK("mdstat", power_sleep_pkg::MD_STATE_ENABLE, rd_val[2:0])
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    check_reset();
    reg_read(power_sleep_pkg::PID_OFS, rd_val);
    `CHK("id", power_sleep_pkg::PID_VALUE, rd_val)
    reg_read(12'h004, rd_val);
    `CHK("unmapped", 32'h0, rd_val)
    reg_write(power_sleep_pkg::TR_STAT_OFS, 32'hFFFF_FFFF);
    reg_read(power_sleep_pkg::TR_STAT_OFS, rd_val);
    `CHK("pending_ro", 32'h0, rd_val)
    reg_read(power_sleep_pkg::PDSTAT_OFS, rd_val);
    `CHK("pdstat_rst", 32'h1, rd_val)
    reg_write(power_sleep_pkg::DOM_CTL_BASE, 32'h0);
    reg_write(power_sleep_pkg::TR_CMD_OFS, 32'h1);
    wait_idle(0);
    `CHK("pd0_on", 1'b0, mem_sleep[0])
    // random next state that is never enable
    seed = lfsr(seed);
    reg_write(ofs(power_sleep_pkg::MOD_CTL_BASE, 9),
              {seed[31:3], (seed[2:0] == 3'h3) ? 3'h0 : seed[2:0]});
    for (int i = 1; i < 6; i++) begin
      seed = lfsr(seed);
      slow <= seed[0];
      go(i, mods[i - 1]);
    end
    `CHK("md9_off", 1'b0, module_reset_n[9])
    `CHK("md2_off", 1'b0, module_reset_n[2])
    reg_read(power_sleep_pkg::PDSTAT_OFS, rd_val);
    `CHK("pdstat_all", 32'h3F, rd_val)
    // switching off is refused
    reg_write(ofs(power_sleep_pkg::DOM_CTL_BASE, 1), 32'h0);
    reg_write(ofs(power_sleep_pkg::MOD_CTL_BASE, 6), 32'h0);
    reg_write(power_sleep_pkg::TR_CMD_OFS, 32'h2);
    wait_idle(1);
    `CHK("pd1_stays", 1'b0, mem_sleep[1])
    `CHK("md6_stays", 1'b1, module_reset_n[6])
    for (int c = 0; c < 3; c++) begin
      reg_write(ofs(power_sleep_pkg::MOD_CTL_BASE, 3 + c), 32'h003);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("lreset_on", 1'b0, core_local_reset_n[c])
      `CHK("core_mod", 1'b1, module_reset_n[3 + c])
      reg_write(ofs(power_sleep_pkg::MOD_CTL_BASE, 3 + c), 32'h103);
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("lreset_off", 1'b1, core_local_reset_n[c])
      seed = lfsr(seed);
      @(posedge sys_clk) core_wdog_reset_n <= seed[2:0];
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("wdog", seed[2:0], core_local_reset_n)
      @(posedge sys_clk) core_wdog_reset_n <= 3'h7;
      repeat (2) @(posedge sys_clk);
    end
    check_reset();
    stop_test();
  end
endmodule

`default_nettype wire
